// File: hdl/rx_ptp_cfg_pkg.sv
// package for the receive ptp configuration bank: offsets, resets, fields.
// assumes word addressing on the register port (one index per register).
package rx_ptp_cfg_pkg;

  // ----------------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam logic [11:0] IDX_CORE_REVISION = 12'hb00;
  localparam logic [11:0] IDX_SCRATCH_WORD = 12'hb01;
  localparam logic [11:0] IDX_VARIANT_FIRST = 12'hb02;
  localparam logic [11:0] IDX_VARIANT_MIDDLE = 12'hb03;
  localparam logic [11:0] IDX_VARIANT_LAST = 12'hb04;
  localparam logic [11:0] IDX_MAC_CLOCK_PERIOD = 12'hb05;
  localparam logic [11:0] IDX_SERIAL_LATENCY = 12'hb06;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int PERIOD_W = 20;
  localparam int PERIOD_NS_MSB = 19;
  localparam int PERIOD_NS_LSB = 16;
  localparam int FRAC_MSB = 15;
  localparam int LAT_NS_MSB = 31;
  localparam int LAT_NS_LSB = 16;

  // ----------------------------------------------------------------------
  // reset and fixed values
  // ----------------------------------------------------------------------
  // identity words: arbitrary neutral values
  localparam logic [31:0] CORE_REVISION = 32'h0000_0001;
  localparam logic [31:0] VARIANT_FIRST = 32'h5258_4130;
  localparam logic [31:0] VARIANT_MIDDLE = 32'h5258_4131;
  localparam logic [31:0] VARIANT_LAST = 32'h5258_4132;
  localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
  localparam logic [31:0] LATENCY_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
  // 2.56 ns (390.625 mhz mac clock): 2 ns plus 0.56 * 65536
  localparam logic [19:0] PERIOD_RESET = 20'h2_8f5c;

endpackage

// File: hdl/rx_ptp_cfg_regs.sv
// receive ptp configuration bank: revision, scratch, variant string words,
// mac clock period and serial input latency.
// assumes a word-indexed register port on core_clk_i, master as described.
// Operation
// - fixed read-only revision word; writes leave it unchanged
// - scratch word resets to zero, reads back last write, no effect
// - three read-only variant words, first characters at lowest index
// - period field 20 bits: 19..16 whole ns, 15..0 ns fraction
// - latency 32-bit rw, reset zero: 31..16 whole ns, 15..0 fraction
//
// Added by the designer: the strobed register port.
module rx_ptp_cfg_regs #(
  parameter logic [19:0] PERIOD_DEFAULT = rx_ptp_cfg_pkg::PERIOD_RESET
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [rx_ptp_cfg_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [19:0] rx_period_o,
  output logic [3:0] rx_period_ns_o,
  output logic [15:0] rx_period_frac_o,
  output logic [31:0] rx_latency_o,
  output logic [15:0] rx_latency_ns_o,
  output logic [15:0] rx_latency_frac_o
);

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic [31:0] scratch_r;
  logic [19:0] period_r;
  logic [31:0] latency_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic hit_page;
  logic [11:0] idx;
  logic wr_scratch;
  logic wr_period;
  logic wr_latency;

  // indices are 12 bits; upper address bits must be zero to hit
  assign hit_page = (reg_addr_i[rx_ptp_cfg_pkg::ADDR_W-1:12] == 2'h0);
  assign idx = reg_addr_i[11:0];
  assign wr_scratch = reg_wr_i && hit_page &&
                      (idx == rx_ptp_cfg_pkg::IDX_SCRATCH_WORD);
  assign wr_period = reg_wr_i && hit_page &&
                     (idx == rx_ptp_cfg_pkg::IDX_MAC_CLOCK_PERIOD);
  assign wr_latency = reg_wr_i && hit_page &&
                      (idx == rx_ptp_cfg_pkg::IDX_SERIAL_LATENCY);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scratch_r <= rx_ptp_cfg_pkg::SCRATCH_RESET;
    end else if (wr_scratch) begin
      scratch_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      period_r <= PERIOD_DEFAULT;
    end else if (wr_period) begin
      period_r <= reg_wdata_i[rx_ptp_cfg_pkg::PERIOD_W-1:0];
    end
  end

  // software is trusted to load a sane latency; hardware never checks it
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latency_r <= rx_ptp_cfg_pkg::LATENCY_RESET;
    end else if (wr_latency) begin
      latency_r <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // read path, data valid only in the cycle after the strobe
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_nxt = rx_ptp_cfg_pkg::READ_UNMAPPED;
    if (reg_rd_i && hit_page) begin
      case (idx)
        rx_ptp_cfg_pkg::IDX_CORE_REVISION:
          rdata_nxt = rx_ptp_cfg_pkg::CORE_REVISION;
        rx_ptp_cfg_pkg::IDX_SCRATCH_WORD:
          rdata_nxt = scratch_r;
        rx_ptp_cfg_pkg::IDX_VARIANT_FIRST:
          rdata_nxt = rx_ptp_cfg_pkg::VARIANT_FIRST;
        rx_ptp_cfg_pkg::IDX_VARIANT_MIDDLE:
          rdata_nxt = rx_ptp_cfg_pkg::VARIANT_MIDDLE;
        rx_ptp_cfg_pkg::IDX_VARIANT_LAST:
          rdata_nxt = rx_ptp_cfg_pkg::VARIANT_LAST;
        rx_ptp_cfg_pkg::IDX_MAC_CLOCK_PERIOD:
          rdata_nxt = {12'h000, period_r};
        rx_ptp_cfg_pkg::IDX_SERIAL_LATENCY:
          rdata_nxt = latency_r;
        default:
          rdata_nxt = rx_ptp_cfg_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // read data return to zero outside the answer cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= rx_ptp_cfg_pkg::READ_UNMAPPED;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs to the timestamp logic
  // ----------------------------------------------------------------------
  assign reg_rdata_o = rdata_r;
  assign rx_period_o = period_r;
  assign rx_period_ns_o =
    period_r[rx_ptp_cfg_pkg::PERIOD_NS_MSB:rx_ptp_cfg_pkg::PERIOD_NS_LSB];
  assign rx_period_frac_o = period_r[rx_ptp_cfg_pkg::FRAC_MSB:0];
  assign rx_latency_o = latency_r;
  assign rx_latency_ns_o =
    latency_r[rx_ptp_cfg_pkg::LAT_NS_MSB:rx_ptp_cfg_pkg::LAT_NS_LSB];
  assign rx_latency_frac_o = latency_r[rx_ptp_cfg_pkg::FRAC_MSB:0];

endmodule

// File: tb/rx_ptp_cfg_chk.sv
// assertions on the rx ptp config bank, from its ports only.
// assumes one bank instance; bound in after the module.
module rx_ptp_cfg_chk (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [13:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [19:0] rx_period_o,
  input wire logic [3:0] rx_period_ns_o,
  input wire logic [31:0] rx_latency_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // properties
  // ----
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire [13:0] a = reg_addr_i;
  wire r = reg_rd_i;
  wire w = reg_wr_i;
  wire ws = w && a == 14'hb01;
  wire rs = r && a == 14'hb01;
  chk_rev_fixed: assert property (r && a == 14'hb00 |=>
    reg_rdata_o == rx_ptp_cfg_pkg::CORE_REVISION) else $error("bad rev");
  chk_scratch_rw: assert property (ws ##1 rs |=>
    reg_rdata_o == $past(reg_wdata_i, 2)) else $error("bad scratch");
  chk_name_first: assert property (r && a == 14'hb02 |=>
    reg_rdata_o == rx_ptp_cfg_pkg::VARIANT_FIRST) else $error("bad name");
  chk_period_ns: assert property (rx_period_ns_o ==
    rx_period_o[19:16]) else $error("bad period split");
  chk_period_wr: assert property (w && a == 14'hb05 |=>
    rx_period_o == 20'($past(reg_wdata_i))) else $error("bad period");
  chk_lat_wr: assert property (w && a == 14'hb06 |=>
    rx_latency_o == $past(reg_wdata_i)) else $error("bad latency");
  chk_lat_hold: assert property (!(w && a == 14'hb06) |=>
    $stable(rx_latency_o)) else $error("latency moved");
  cover property (ws ##1 rs);
  cover property (w && a == 14'hb00);
  cover property (r && a == 14'hb06);
endmodule
bind rx_ptp_cfg_regs rx_ptp_cfg_chk rx_ptp_cfg_chk_i (
  .core_clk_i(core_clk_i),
  .arst_n_i(arst_n_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .rx_period_o(rx_period_o),
  .rx_period_ns_o(rx_period_ns_o),
  .rx_latency_o(rx_latency_o)
);

// File: tb/testbench.sv
// bench for the rx ptp config bank: random and corner register traffic.
// assumes package, bank and checker are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [13:0] reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o, rx_latency_o, scr, lat;
  logic [19:0] rx_period_o, per;
  logic [15:0] rx_period_frac_o, rx_latency_ns_o, rx_latency_frac_o;
  logic [3:0] rx_period_ns_o;
  int err_count = 0, checks_done = 0, cyc = 0;
  rx_ptp_cfg_regs rx_ptp_cfg_regs_i (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .rx_period_o(rx_period_o),
    .rx_period_ns_o(rx_period_ns_o),
    .rx_period_frac_o(rx_period_frac_o),
    .rx_latency_o(rx_latency_o),
    .rx_latency_ns_o(rx_latency_ns_o),
    .rx_latency_frac_o(rx_latency_frac_o)
  );
  initial forever #12.5 core_clk_i = ~core_clk_i;
  // ----
  // checks and bus cycles
  // ----
  task test_done();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function logic [31:0] model(logic [13:0] a);
    case (a)
      14'hb00: return rx_ptp_cfg_pkg::CORE_REVISION;
      14'hb01: return scr;
      14'hb02: return rx_ptp_cfg_pkg::VARIANT_FIRST;
      14'hb03: return rx_ptp_cfg_pkg::VARIANT_MIDDLE;
      14'hb04: return rx_ptp_cfg_pkg::VARIANT_LAST;
      14'hb05: return {12'h0, per};
      14'hb06: return lat;
      default: return 32'h0;
    endcase
  endfunction
  // one strobe per cycle; read data checked in the cycle after
  task op(bit w, logic [13:0] a, logic [31:0] d);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    #1;
    if (!w) chk(reg_rdata_o, model(a));
    else chk(reg_rdata_o, 32'h0);
    if (!w) begin
    end else if (a == 14'hb01) scr = d;
    else if (a == 14'hb05) per = d[19:0];
    else if (a == 14'hb06) lat = d;
    chk(rx_latency_o, lat);
    chk(rx_period_o, per);
    chk({rx_latency_ns_o, rx_latency_frac_o}, lat);
    chk({rx_period_ns_o, rx_period_frac_o}, per);
  endtask
  task rst();
    arst_n_i <= 0;
    reg_wr_i <= 0;
    reg_rd_i <= 0;
    repeat (4) @(posedge core_clk_i);
    arst_n_i <= 1;
    scr = 0;
    per = rx_ptp_cfg_pkg::PERIOD_RESET;
    lat = 0;
    for (int i = 0; i < 9; i++) op(0, 14'hb00 + 14'(i), 0);
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 1500) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h410bc01f));
    rst();
    op(1, 14'hb06, 32'h0009_f148);
    op(1, 14'hb05, 32'hffff_ffff);
    op(0, 14'hb05, 0);
    op(1, 14'h3b01, 32'h1234_5678);
    op(0, 14'hb01, 0);
    repeat (400) op(1'($urandom),
      14'hb00 + 14'($urandom_range(8)), $urandom);
    rst();
    test_done();
  end
endmodule
